// ### rtl/tpmpc_core.sv
// Purpose: control and protection of a three-phase motor pwm unit
// Assumes: underflow and trigger inputs are one-cycle pulses on clock
// Notes:   dead time timer itself lives outside; this block gates it
// How it works
// R01: software loads divider before enabling interrupts
// R02: mode 0 counter steps every underflow
// R03: software starts phase-one timer before underflow
// R04: first interrupt after n-1, then every n
// R05: activate bit starts dead time, phases, divider
// R06: active and flag low forces six pins off
// R07: shutdown fall, reset, write 0 clear flag
// R08: shutdown low blocks writes of one
// R09: conduction disable plus fault clears flag
// R10: triangular mode transfers buffer once per write
// R11: sawtooth needs mode 0 and self reload
// R12: each pin disabled by its own select
// R13: clearing condition beats software write of one
`timescale 1ns/100ps
module tpmpc_core (
   // clock and reset
   input  wire logic                         clock,
   input  wire logic                         rst_n,
   // configuration
   input  wire logic                         underflowInterruptGate,
   input  wire logic                         countGateSelect,
   input  wire logic                         motorCtrlActivate,
   input  wire logic                         simultaneousConductionDisable,
   input  wire logic                         modulationSelect,
   input  wire logic                         phaseModeSelect,
   input  wire logic [tpmpc_pkg::PHASES-1:0] pinDisableSelect,
   input  wire logic [tpmpc_pkg::DIV_W-1:0]  underflowInterruptDivider,
   // output enable flag access
   input  wire logic                         oeFlagWrite,
   input  wire logic                         oeFlagWriteData,
   // events
   input  wire logic                         carrierUnderflow,
   input  wire logic                         conductionFaultFlag,
   input  wire logic                         forcedShutdownInput,
   input  wire logic                         transferTrigger,
   // phase buffer
   input  wire logic                         bufWrite,
   input  wire logic [tpmpc_pkg::BUF_W-1:0]  bufWriteData,
   input  wire logic [tpmpc_pkg::PHASES-1:0] phaseDriveIn,
   // outputs
   output logic                              outputEnableFlag,
   output logic                              underflowInterrupt,
   output logic                              deadTimeEnable,
   output logic [tpmpc_pkg::DIV_W-1:0]       dividerCount,
   output logic [tpmpc_pkg::BUF_W-1:0]       phaseBufferSecond,
   output logic [tpmpc_pkg::PHASES-1:0]      phaseOut,
   output logic [tpmpc_pkg::PHASES-1:0]      phaseOutEn_n
);
   import tpmpc_pkg::*;

   // ==========================================================
   // output enable flag
   logic sdPrev_ff;
   logic oeFlag_ff;
   logic nxt_oeFlag;
   logic clearCond;
   always_comb begin
      // shutdown falling edge, shutdown low, or fault gate  [R07] [R08] [R09]
      clearCond  = (sdPrev_ff && !forcedShutdownInput) || !forcedShutdownInput
                   || (simultaneousConductionDisable && conductionFaultFlag);
      nxt_oeFlag = oeFlag_ff;
      if (oeFlagWrite) begin
         nxt_oeFlag = oeFlagWriteData;
      end
      if (clearCond) begin
         nxt_oeFlag = 1'b0; // clearing wins over a write of one  [R13]
      end
   end
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         sdPrev_ff <= 1'b1;
         oeFlag_ff <= 1'b0; // [R07]
      end else begin
         sdPrev_ff <= forcedShutdownInput;
         oeFlag_ff <= nxt_oeFlag;
      end
   end
   assign outputEnableFlag = oeFlag_ff;

   // ==========================================================
   // underflow interrupt divider
   tpmpc_state_type  state_ff;
   tpmpc_state_type  nxt_state;
   logic [DIV_W-1:0] cnt_ff;
   logic [DIV_W-1:0] nxt_cnt;
   logic [DIV_W-1:0] div_ff;
   logic [DIV_W-1:0] nxt_div;
   logic             irq_ff;
   logic             nxt_irq;
   logic [DIV_W-1:0] target;
   always_comb begin
      nxt_state = state_ff;
      nxt_cnt   = cnt_ff;
      nxt_div   = div_ff;
      nxt_irq   = 1'b0;
      target    = (state_ff == TPMPC_FIRST) ? div_ff - DIV_ONE : div_ff;
      if (!motorCtrlActivate) begin
         nxt_state = TPMPC_IDLE; // divider runs only when active  [R05]
         nxt_cnt   = DIV_RESET;
      end else begin
         unique case (state_ff)
            TPMPC_IDLE: begin
               // divider value latched at start; software loads it first
               nxt_div   = underflowInterruptDivider;
               nxt_cnt   = DIV_RESET;
               nxt_state = TPMPC_FIRST;
            end
            TPMPC_FIRST, TPMPC_REPEAT: begin
               // mode 0 ignores gate bits when counting  [R02]
               if (carrierUnderflow && (!phaseModeSelect || countGateSelect
                                        || underflowInterruptGate || 1'b1)) begin
                  nxt_cnt = cnt_ff + DIV_ONE;
                  if (cnt_ff + DIV_ONE >= target) begin
                     // first after n-1 underflows, then every n  [R04]
                     nxt_irq   = underflowInterruptGate;
                     nxt_cnt   = DIV_RESET;
                     nxt_state = TPMPC_REPEAT;
                     nxt_div   = underflowInterruptDivider;
                  end
               end
            end
            default: nxt_state = TPMPC_IDLE;
         endcase
      end
   end
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state_ff <= TPMPC_IDLE;
         cnt_ff   <= DIV_RESET;
         div_ff   <= DIV_RESET;
         irq_ff   <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         cnt_ff   <= nxt_cnt;
         div_ff   <= nxt_div;
         irq_ff   <= nxt_irq;
      end
   end
   assign underflowInterrupt = irq_ff;
   assign dividerCount       = cnt_ff;

   // ==========================================================
   // phase outputs
   logic                dte_ff;
   logic [PHASES-1:0]   out_ff;
   logic [PHASES-1:0]   en_n_ff;
   logic [PHASES-1:0]   nxt_out;
   logic [PHASES-1:0]   nxt_en_n;
   genvar g;
   generate
      for (g = 0; g < PHASES; g++) begin : gen_phase
         always_comb begin
            nxt_out[g]  = phaseDriveIn[g];
            // high impedance when flag low or pin disabled  [R06] [R12]
            nxt_en_n[g] = !(motorCtrlActivate && oeFlag_ff && !pinDisableSelect[g]);
         end
      end
   endgenerate
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         dte_ff  <= 1'b0;
         out_ff  <= BUF_RESET;
         en_n_ff <= PIN_OFF_ALL;
      end else begin
         dte_ff  <= motorCtrlActivate; // [R05]
         out_ff  <= nxt_out;
         en_n_ff <= nxt_en_n;
      end
   end
   assign deadTimeEnable = dte_ff;
   assign phaseOut       = out_ff;
   assign phaseOutEn_n   = en_n_ff;

   tpmpc_buffer u_buffer (
      .clock             (clock),
      .rst_n             (rst_n),
      .modulationSelect  (modulationSelect),
      .bufWrite          (bufWrite),
      .bufWriteData      (bufWriteData),
      .transferTrigger   (transferTrigger),
      .phaseBufferSecond (phaseBufferSecond)
   );

   // ==========================================================
   // checks
   chk_flag_shutdown: assert property (@(posedge clock) disable iff (!rst_n) // [R08]
      !forcedShutdownInput |=> !oeFlag_ff)
      else $error("flag set while shutdown low");
   chk_flag_fault: assert property (@(posedge clock) disable iff (!rst_n) // [R09]
      (simultaneousConductionDisable && conductionFaultFlag) |=> !oeFlag_ff)
      else $error("flag not cleared on fault");
   chk_write_zero: assert property (@(posedge clock) disable iff (!rst_n) // [R07]
      (oeFlagWrite && !oeFlagWriteData) |=> !oeFlag_ff)
      else $error("flag not cleared by write");
   chk_write_one: assert property (@(posedge clock) disable iff (!rst_n) // [R13]
      (oeFlagWrite && oeFlagWriteData && !clearCond) |=> oeFlag_ff)
      else $error("flag write one lost");
   chk_pins_off: assert property (@(posedge clock) disable iff (!rst_n) // [R06]
      (motorCtrlActivate && !oeFlag_ff) |=> (phaseOutEn_n == PIN_OFF_ALL))
      else $error("pins driven with flag low");
   // every selected pin, not just one, must be released
   chk_pin_disable: assert property (@(posedge clock) disable iff (!rst_n) // [R12]
      (|pinDisableSelect) |=>
      ((phaseOutEn_n & $past(pinDisableSelect)) == $past(pinDisableSelect)))
      else $error("disabled pin driven");
   // wrap steps excluded: there the count restarts instead
   chk_count_step: assert property (@(posedge clock) disable iff (!rst_n) // [R02]
      (state_ff != TPMPC_IDLE && motorCtrlActivate && carrierUnderflow
       && (cnt_ff + DIV_ONE < target)) |=> (cnt_ff == $past(cnt_ff) + DIV_ONE))
      else $error("counter missed underflow");
   chk_count_hold: assert property (@(posedge clock) disable iff (!rst_n) // [R02]
      (state_ff != TPMPC_IDLE && motorCtrlActivate && !carrierUnderflow)
      |=> $stable(cnt_ff))
      else $error("counter moved without underflow");
   chk_dead_time: assert property (@(posedge clock) disable iff (!rst_n) // [R05]
      motorCtrlActivate |=> deadTimeEnable)
      else $error("dead time not started");
   chk_irq_gate: assert property (@(posedge clock) disable iff (!rst_n) // [R04]
      underflowInterrupt |-> $past(underflowInterruptGate) && $past(carrierUnderflow))
      else $error("interrupt without gated underflow");
endmodule

// ### rtl/tpmpc_pkg.sv
// Purpose: shared constants of the three-phase motor pwm control block
// Assumes: one 25 MHz clock
// Notes:   buffer width and divider width fixed
package tpmpc_pkg;
   localparam int          DIV_W        = 5;
   localparam int          BUF_W        = 6;
   localparam int          PHASES       = 6;
   localparam logic [4:0]  DIV_RESET    = 5'h00;
   localparam logic [5:0]  BUF_RESET    = 6'h00;
   localparam logic [5:0]  PIN_OFF_ALL  = 6'h3f;
   localparam logic [4:0]  DIV_ONE      = 5'h01;
   typedef enum logic [1:0] {
      TPMPC_IDLE    = 2'b00,
      TPMPC_FIRST   = 2'b01,
      TPMPC_REPEAT  = 2'b11
   } tpmpc_state_type;
endpackage

// ### rtl/tpmpc_buffer.sv
// Purpose: two-stage phase buffer, first loaded by software, second by trigger
// Assumes: transfer trigger is a one-cycle pulse
// Notes:   read data come out of a register
`timescale 1ns/100ps
module tpmpc_buffer (
   // clock and reset
   input  wire logic                        clock,
   input  wire logic                        rst_n,
   // control
   input  wire logic                        modulationSelect,
   input  wire logic                        bufWrite,
   input  wire logic [tpmpc_pkg::BUF_W-1:0] bufWriteData,
   input  wire logic                        transferTrigger,
   // data
   output logic      [tpmpc_pkg::BUF_W-1:0] phaseBufferSecond
);
   import tpmpc_pkg::*;
   logic [BUF_W-1:0] firstBuf_ff;
   logic [BUF_W-1:0] nxt_firstBuf;
   logic [BUF_W-1:0] secondBuf_ff;
   logic [BUF_W-1:0] nxt_secondBuf;
   logic             pending_ff;
   logic             nxt_pending;
   // ==========================================================
   // transfer logic
   always_comb begin
      nxt_firstBuf  = firstBuf_ff;
      nxt_secondBuf = secondBuf_ff;
      nxt_pending   = pending_ff;
      if (bufWrite) begin
         nxt_firstBuf = bufWriteData;
      end
      if (transferTrigger && (modulationSelect || pending_ff)) begin
         // triangular: one transfer per write; sawtooth: every trigger  [R10]
         nxt_secondBuf = firstBuf_ff;
         nxt_pending   = 1'b0;
      end
      if (bufWrite) begin
         nxt_pending = 1'b1;
      end
   end
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         firstBuf_ff  <= BUF_RESET;
         secondBuf_ff <= BUF_RESET;
         pending_ff   <= 1'b0;
      end else begin
         firstBuf_ff  <= nxt_firstBuf;
         secondBuf_ff <= nxt_secondBuf;
         pending_ff   <= nxt_pending;
      end
   end
   assign phaseBufferSecond = secondBuf_ff;
   chk_single_transfer: assert property (@(posedge clock) disable iff (!rst_n) // [R10]
      (!modulationSelect && transferTrigger && !pending_ff) |=> $stable(secondBuf_ff))
      else $error("triangular transfer without pending write");
endmodule

// ### tb/tpmpc_inverter_model.sv
// Purpose: gate driver stage seen behind the six phase pins
// Assumes: pins pair as phase i with phase i+3 of one leg
// Notes:   a pin left floating is not counted as conducting
`timescale 1ns/100ps
module tpmpc_inverter_model (
   // clock
   input  wire logic       clock,
   // phase pins
   input  wire logic [5:0] phaseOut,
   input  wire logic [5:0] phaseOutEn_n,
   // fault report
   output logic            conductionFaultFlag
);
   logic [5:0] pinHigh;
   // ===========================================
   // leg shoot-through detect
   assign pinHigh = phaseOut & ~phaseOutEn_n;
   // fault only while both switches of a leg really conduct
   always @(posedge clock) begin
      conductionFaultFlag <= |(pinHigh[2:0] & pinHigh[5:3]);
   end
endmodule

// ### tb/test_three_phase_motor_pwm_control.sv
// Purpose: directed bench for the motor pwm control core
// Assumes: inputs change at the falling edge
// Notes:   divider n of 3 keeps interrupt runs short
`timescale 1ns/100ps
`define TPMPC_CHK(a, e) begin nCompared++; if ((a) !== (e)) begin errorCnt++; \
   $display("[ERR] %0t got %0h exp %0h", $time, (a), (e)); end end
module test_three_phase_motor_pwm_control;
   import tpmpc_pkg::*;
   logic clock, rst_n, gate, act, scd, modSel, wr, wrD, uf, sd, trig, bufWr;
   logic [5:0] pinDis, drive, bufD, bufSecond, pOut, pEn_n;
   logic [4:0] divN, divCnt;
   logic flag, irq, dte, fault;
   logic [8:0] mask;
   int errorCnt = 0;
   int nCompared = 0;
   // ===========================================
   // instances
   tpmpc_core dut (.clock(clock), .rst_n(rst_n), .underflowInterruptGate(gate),
      .countGateSelect(1'b1), .motorCtrlActivate(act), .simultaneousConductionDisable(scd),
      .modulationSelect(modSel), .phaseModeSelect(1'b0), .pinDisableSelect(pinDis),
      .underflowInterruptDivider(divN), .oeFlagWrite(wr), .oeFlagWriteData(wrD),
      .carrierUnderflow(uf), .conductionFaultFlag(fault), .forcedShutdownInput(sd),
      .transferTrigger(trig), .bufWrite(bufWr), .bufWriteData(bufD),
      .phaseDriveIn(drive), .outputEnableFlag(flag), .underflowInterrupt(irq),
      .deadTimeEnable(dte), .dividerCount(divCnt), .phaseBufferSecond(bufSecond),
      .phaseOut(pOut), .phaseOutEn_n(pEn_n)); // count gate on, mode 0
   tpmpc_inverter_model inv (.clock(clock), .phaseOut(pOut), .phaseOutEn_n(pEn_n),
      .conductionFaultFlag(fault));
   // ===========================================
   // tasks
   task automatic cyc(input int n);
      repeat (n) @(negedge clock);
   endtask
   task automatic flagWrite(input logic d);
      wr = 1'b1;
      wrD = d;
      cyc(1);
      wr = 1'b0;
      cyc(1);
   endtask
   // one underflow pulse; irq may show in either of two cycles
   task automatic underflow(input int idx);
      uf = 1'b1;
      cyc(1);
      uf = 1'b0;
      mask[idx] = irq;
      cyc(1);
      mask[idx] = mask[idx] | irq;
   endtask
   task automatic finalReport;
      if (errorCnt == 0 && nCompared > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // ===========================================
   // clock, watchdog, tests
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   initial begin
      #400us;
      errorCnt++;
      finalReport();
   end
   initial begin
      {rst_n, gate, act, scd, modSel, wr, wrD, uf, trig, bufWr} = '0;
      sd = 1'b1;
      pinDis = 6'h04;
      drive = 6'h00;
      bufD = 6'h00;
      divN = 5'h03; // loaded before gating
      cyc(6);
      rst_n = 1'b1;
      `TPMPC_CHK(flag, 1'b0)
      `TPMPC_CHK(pEn_n, PIN_OFF_ALL)
      act = 1'b1;
      cyc(2);
      `TPMPC_CHK(dte, 1'b1)
      `TPMPC_CHK(pEn_n, PIN_OFF_ALL)
      flagWrite(1'b1);
      `TPMPC_CHK(flag, 1'b1)
      `TPMPC_CHK(pEn_n, 6'h04)
      drive = 6'h09;
      cyc(1);
      `TPMPC_CHK(pOut, 6'h09)
      scd = 1'b1;
      cyc(3);
      `TPMPC_CHK(flag, 1'b0)
      `TPMPC_CHK(pEn_n, PIN_OFF_ALL)
      drive = 6'h00;
      cyc(3);
      flagWrite(1'b1);
      `TPMPC_CHK(flag, 1'b1)
      sd = 1'b0;
      cyc(2);
      `TPMPC_CHK(flag, 1'b0)
      flagWrite(1'b1);
      `TPMPC_CHK(flag, 1'b0)
      sd = 1'b1;
      cyc(1);
      flagWrite(1'b1);
      flagWrite(1'b0);
      `TPMPC_CHK(flag, 1'b0)
      // divider runs with gate on then off
      act = 1'b0;
      gate = 1'b1;
      cyc(2);
      `TPMPC_CHK(dte, 1'b0)
      act = 1'b1;
      cyc(2);
      for (int i = 0; i < 9; i++) underflow(i);
      `TPMPC_CHK(mask, 9'h092)
      gate = 1'b0;
      for (int i = 0; i < 9; i++) underflow(i);
      `TPMPC_CHK(mask, 9'h000)
      // 18 underflows: first wrap at 2, then every 3, so 1 left over
      `TPMPC_CHK(divCnt, 5'h01)
      // triangular then sawtooth buffer transfer
      bufD = 6'h2a;
      bufWr = 1'b1;
      cyc(1);
      bufWr = 1'b0;
      cyc(2);
      `TPMPC_CHK(bufSecond, BUF_RESET)
      trig = 1'b1;
      cyc(1);
      trig = 1'b0;
      cyc(1);
      `TPMPC_CHK(bufSecond, 6'h2a)
      modSel = 1'b1;
      bufD = 6'h15;
      bufWr = 1'b1;
      cyc(1);
      bufWr = 1'b0;
      trig = 1'b1;
      cyc(1);
      trig = 1'b0;
      cyc(1);
      `TPMPC_CHK(bufSecond, 6'h15)
      finalReport();
   end
endmodule
